// [rtl/ufc_defines.vh]
`ifndef UFC_DEFINES_VH
`define UFC_DEFINES_VH

// Register indexes on the plain register port
`define UFC_A_MODE1   4'h0
`define UFC_A_MODE2   4'h1
`define UFC_A_TEST    4'h2
`define UFC_A_CSEL    4'h3
`define UFC_A_AUX     4'h4
`define UFC_A_CMD     4'h5
`define UFC_A_OPSET   4'h6
`define UFC_A_OPCLR   4'h7
`define UFC_A_STAT    4'h8
`define UFC_A_DATA    4'h9
`define UFC_A_BRGT    4'ha

// Field positions
`define UFC_M1_RTS    7
`define UFC_M1_WK_HI  4
`define UFC_M1_WK_LO  3
`define UFC_M2_TXMP   5
`define UFC_M2_CTS    4
`define UFC_TEST_1X   0
`define UFC_AUX_SET   7
`define UFC_CMD_HI    7
`define UFC_CMD_LO    4
`define UFC_CS_HI     7
`define UFC_CS_LO     4
`define UFC_OP_RTS    0

// Mode and command codes
`define UFC_WAKE_MODE 2'b11
`define UFC_CMD_RXEN  4'h1
`define UFC_CMD_RXDIS 4'h2
`define UFC_CMD_TXEN  4'h3
`define UFC_CMD_TXDIS 4'h4
`define UFC_CMD_RXRST 4'h5
`define UFC_CMD_RTSON 4'h8
`define UFC_CMD_RTSOF 4'h9
`define UFC_CS_TIMER  4'hd
`define UFC_CS_EXT16  4'he
`define UFC_CS_EXT1   4'hf

// Reset values
`define UFC_RST_BYTE  8'h00
`define UFC_RST_RATE  18'h00000

// Timing: clock 100 MHz, rates held as twice the baud rate
`define UFC_CLK2_HZ   28'hbebc200
`define UFC_OS_SHIFT  4
`define UFC_SUB_LAST  4'hf
`define UFC_SUB_MID   4'h7
`define UFC_TX_COMMIT 4'h2
`define UFC_LAST_BIT  4'h7
`define UFC_STOP_BIT  4'h8
`define UFC_FIFO_FULL 2'h3
`define UFC_PTR_LAST  2'h2

`endif

// [rtl/ufc_baud.v]
`timescale 1ns/100ps
`include "ufc_defines.vh"

// Bit-rate tick source: fixed table, timer or external clock
module ufc_baud (
	input  wire       clk_i,
	input  wire       srst_i,
	input  wire       ce_i,
	input  wire [3:0] code_i,
	input  wire       rate_set_i,
	input  wire       rate_test_i,
	input  wire       test_1x_i,
	input  wire       timer_tick_i,
	input  wire       ext_clk_i,
	output reg        tick_o,
	output reg        one_x_o
);

	reg  [27:0] acc;     // Phase accumulator
	reg         ext_q;   // Previous external clock level
	wire [17:0] rate2;   // Twice the selected baud rate
	wire [27:0] incr;    // Accumulator step
	wire [27:0] sum;     // Accumulator next sum
	wire        ext_rise;

	// Twice the baud rate; halves avoid a fractional 134.5
	function [17:0] ufc_rate2;
		input [3:0] code;
		input       set;
		input       test;
		begin
			case ({test, set, code})
				6'h00: ufc_rate2 = 18'h00064;
				6'h10: ufc_rate2 = 18'h00096;
				6'h20: ufc_rate2 = 18'h02580;
				6'h30: ufc_rate2 = 18'h03840;
				6'h01, 6'h11: ufc_rate2 = 18'h000dc;
				6'h21, 6'h31: ufc_rate2 = 18'h006e0;
				6'h02, 6'h12: ufc_rate2 = 18'h0010d;
				6'h22, 6'h32: ufc_rate2 = 18'h00868;
				6'h03: ufc_rate2 = 18'h00190;
				6'h13: ufc_rate2 = 18'h0012c;
				6'h23: ufc_rate2 = 18'h09600;
				6'h33: ufc_rate2 = 18'h07080;
				6'h04, 6'h14: ufc_rate2 = 18'h00258;
				6'h24, 6'h34: ufc_rate2 = 18'h0e100;
				6'h05, 6'h15: ufc_rate2 = 18'h004b0;
				6'h25, 6'h35: ufc_rate2 = 18'h1c200;
				6'h06, 6'h16: ufc_rate2 = 18'h00960;
				6'h26, 6'h36: ufc_rate2 = 18'h38400;
				6'h07, 6'h27: ufc_rate2 = 18'h00834;
				6'h17, 6'h37: ufc_rate2 = 18'h00fa0;
				6'h08, 6'h18: ufc_rate2 = 18'h012c0;
				6'h28, 6'h38: ufc_rate2 = 18'h1c200;
				6'h09, 6'h19, 6'h29, 6'h39: ufc_rate2 = 18'h02580;
				6'h0a: ufc_rate2 = 18'h03840;
				6'h1a: ufc_rate2 = 18'h00e10;
				6'h2a: ufc_rate2 = 18'h1c200;
				6'h3a: ufc_rate2 = 18'h07080;
				6'h0b, 6'h1b, 6'h2b, 6'h3b: ufc_rate2 = 18'h04b00;
				6'h0c, 6'h2c: ufc_rate2 = 18'h12c00;
				6'h1c, 6'h3c: ufc_rate2 = 18'h09600;
				default: ufc_rate2 = `UFC_RST_RATE;
			endcase
		end
	endfunction

	assign rate2 = ufc_rate2(code_i, rate_set_i, rate_test_i);
	// 1x steps once a bit, 16x sixteen times
	assign incr = one_x_o ? {10'h000, rate2} : {6'h00, rate2, 4'h0};
	assign sum = acc + incr;
	assign ext_rise = ext_clk_i & ~ext_q;

	// Tick generation; exact on average, jitter one clock
	always @(posedge clk_i) begin
		if (srst_i) begin
			acc     <= 28'h0000000;
			ext_q   <= 1'b0;
			tick_o  <= 1'b0;
			one_x_o <= 1'b0;
		end else if (ce_i) begin
			ext_q   <= ext_clk_i;
			one_x_o <= test_1x_i | (code_i == `UFC_CS_EXT1);
			case (code_i)
				`UFC_CS_TIMER: tick_o <= timer_tick_i;
				`UFC_CS_EXT16, `UFC_CS_EXT1: tick_o <= ext_rise;
				default: begin
					if (sum >= `UFC_CLK2_HZ) begin
						acc    <= sum - `UFC_CLK2_HZ;
						tick_o <= 1'b1;
					end else begin
						acc    <= sum;
						tick_o <= 1'b0;
					end
				end
			endcase
		end
	end

endmodule

// [rtl/ufc_tx.v]
`timescale 1ns/100ps
`include "ufc_defines.vh"

// Transmitter: holding register, shift register, gating
module ufc_tx (
	input  wire       clk_i,
	input  wire       srst_i,
	input  wire       ce_i,
	input  wire       tick_i,
	input  wire       one_x_i,
	input  wire       load_i,
	input  wire [7:0] data_i,
	input  wire       enable_i,
	input  wire       disable_i,
	input  wire       cts_gate_i,
	input  wire       cts_n_i,
	output reg        line_o,
	output reg        ready_o,
	output reg        empty_o,
	output reg        enabled_o
);

	localparam S_IDLE  = 4'b0001;
	localparam S_PEND  = 4'b0010;
	localparam S_START = 4'b0100;
	localparam S_SHIFT = 4'b1000;

	reg [3:0] state;     // One-hot state
	reg [7:0] hold;      // Holding register
	reg       hold_full; // Holding register occupied
	reg [7:0] shreg;     // Shift register
	reg [3:0] sub;       // Tick count within a bit
	reg [3:0] bitn;      // Data bit index, stop at end
	wire      bit_end;   // Last tick of a bit
	wire      cts_ok;

	assign bit_end = tick_i & (one_x_i | (sub == `UFC_SUB_LAST));
	assign cts_ok = ~cts_gate_i | ~cts_n_i;

	// Character sequencing
	always @(posedge clk_i) begin
		if (srst_i) begin
			state     <= S_IDLE;
			hold      <= `UFC_RST_BYTE;
			hold_full <= 1'b0;
			shreg     <= `UFC_RST_BYTE;
			sub       <= 4'h0;
			bitn      <= 4'h0;
			line_o    <= 1'b1;
			ready_o   <= 1'b0;
			empty_o   <= 1'b1;
			enabled_o <= 1'b0;
		end else if (ce_i) begin
			if (enable_i) begin
				enabled_o <= 1'b1;
				empty_o   <= 1'b1;
				ready_o   <= ~hold_full;
			end else if (disable_i) begin
				enabled_o <= 1'b0;
				ready_o   <= 1'b0;
			end
			// Loads only accepted while ready
			if (load_i && ready_o) begin
				hold      <= data_i;
				hold_full <= 1'b1;
				ready_o   <= 1'b0;
			end
			if (tick_i)
				sub <= sub + 4'h1;
			case (state)
				S_IDLE: begin
					if (enabled_o && hold_full && cts_ok && !disable_i) begin
						state <= S_PEND;
						sub   <= 4'h0;
					end
				end
				S_PEND: begin
					if (disable_i) begin
						hold_full <= 1'b0;
						state     <= S_IDLE;
					end else if (tick_i && (one_x_i || sub == `UFC_TX_COMMIT)) begin
						shreg     <= hold;
						hold_full <= 1'b0;
						empty_o   <= 1'b0;
						line_o    <= 1'b0;
						state     <= S_START;
						sub       <= 4'h0;
					end
				end
				S_START: begin
					if (bit_end) begin
						ready_o <= enabled_o;
						line_o  <= shreg[0];
						bitn    <= 4'h0;
						state   <= S_SHIFT;
					end
				end
				S_SHIFT: begin
					if (bit_end) begin
						if (bitn == `UFC_STOP_BIT) begin
							// Stop bit finished
							state   <= S_IDLE;
							empty_o <= ~hold_full;
						end else if (bitn == `UFC_LAST_BIT) begin
							line_o <= 1'b1;
							bitn   <= bitn + 4'h1;
						end else begin
							line_o <= shreg[bitn[2:0] + 3'h1];
							bitn   <= bitn + 4'h1;
						end
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

endmodule

// [rtl/ufc_top.v]
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "ufc_defines.vh"

// Function
// - Clear-to-send input is active low
// - Request-to-send pin is active low
// - Gate on, pin high: stop after character
// - Gate off: clear-to-send pin ignored
// - Full FIFO plus fourth start negates request
// - Receive mode bit hands pin to receiver
// - Transmitter control shows last byte sent
// - Two commands assert and negate request
// - Pin is NAND of port bit, receiver, transmitter
// - Flow enable keeps port bit unchanged
// - Very early disable sends nothing
// - Underrun load then disable during pending start sends nothing
// - Empty flag set in underrun or enable
// - Transfer during start, ready after start
// - Test address forces 1x, exposes nodes
// - Each read of the rate-test address toggles alternate rate table
// - Code and set bit choose rate
// - Rate test maps codes to alternates
// - Receiver reset keeps all programming
// - Wake mode blocks receiver disable and reset
module ufc_top (
	input  wire       clk_i,
	input  wire       srst_i,
	input  wire       ce_i,
	input  wire [3:0] addr_i,
	input  wire [7:0] wdata_i,
	input  wire       wr_i,
	input  wire       rd_i,
	input  wire       clear_to_send_n_i,
	input  wire       rx_i,
	input  wire       external_clock_input_i,
	input  wire       rx_hw_reset_i,
	input  wire       timer_tick_i,
	output reg  [7:0] rdata_o,
	output wire       tx_o,
	output reg        request_to_send_n_o,
	output reg  [7:0] output_port_o,
	output wire       transmitter_ready_flag_o,
	output wire       transmitter_empty_flag_o
);

	localparam R_IDLE  = 4'b0001;
	localparam R_START = 4'b0010;
	localparam R_DATA  = 4'b0100;
	localparam R_STOP  = 4'b1000;

	// Software-visible registers
	reg  [7:0] mode1;         // Flow enable, wake field
	reg  [7:0] mode2;         // Transmit gate, pin ownership
	reg  [7:0] test_reg;      // 1x test mode
	reg  [7:0] csel;          // Clock select code
	reg  [7:0] aux;           // Rate set select
	reg  [7:0] opr;           // Output port register
	reg        rate_test;     // Alternate table active

	// Pin synchronisers, two stages each
	reg  [1:0] cts_s;
	reg  [1:0] rx_s;
	reg  [1:0] ext_s;
	reg  [1:0] hwr_s;

	// Receiver state
	reg  [3:0] rstate;        // One-hot receiver state
	reg  [3:0] rsub;          // Tick count within a bit
	reg  [2:0] rbit;          // Data bit index
	reg  [7:0] rshift;        // Receive shift register
	reg        rwait;         // Fourth char held in shifter
	reg        rx_en;         // Receiver enabled
	reg        rts_hold;      // Receiver wants remote stopped
	reg  [7:0] fifo_mem [0:2];// Three-deep receive FIFO
	reg  [1:0] wr_ptr;
	reg  [1:0] rd_ptr;
	reg  [1:0] count;

	wire       tick;          // Bit-rate tick
	wire       one_x;         // 1x clocking in force
	wire [3:0] cmd;           // Command code field
	wire       cmd_wr;
	wire       wake;          // Wake-up mode selected
	wire       rx_reset;      // Effective receiver reset
	wire       rx_disable;    // Effective receiver disable
	wire       pop;           // Host takes a character
	wire       push_new;      // Finished char into FIFO
	wire       push;          // Any write into FIFO
	wire [7:0] push_data;
	wire       rx_mid;        // Start-bit check point
	wire       rx_sample;     // Data sample point
	wire       start_seen;    // Low line found while idle
	wire       rx_pin;        // Synchronised receive line
	wire       pin_term;      // Receiver and transmitter term
	wire       tx_ready;
	wire       tx_empty;
	wire       tx_enabled;

	// Wrap a FIFO pointer at three entries
	function [1:0] ufc_next_ptr;
		input [1:0] p;
		begin
			ufc_next_ptr = (p == `UFC_PTR_LAST) ? 2'h0 : p + 2'h1;
		end
	endfunction

	// Strobe decode used by several processes
	function ufc_hit;
		input       strobe;
		input [3:0] a;
		input [3:0] want;
		begin
			ufc_hit = strobe & (a == want);
		end
	endfunction

	assign cmd      = wdata_i[`UFC_CMD_HI:`UFC_CMD_LO];
	assign cmd_wr   = ufc_hit(wr_i, addr_i, `UFC_A_CMD);
	assign wake     = (mode1[`UFC_M1_WK_HI:`UFC_M1_WK_LO] == `UFC_WAKE_MODE);
	assign rx_reset   = ~wake & ((cmd_wr & (cmd == `UFC_CMD_RXRST)) | hwr_s[1]);
	assign rx_disable = ~wake & cmd_wr & (cmd == `UFC_CMD_RXDIS);
	assign pop        = ufc_hit(rd_i, addr_i, `UFC_A_DATA) & (count != 2'h0);
	assign rx_pin     = rx_s[1];
	assign rx_mid     = tick & (one_x | (rsub == `UFC_SUB_MID));
	assign rx_sample  = tick & (one_x | (rsub == `UFC_SUB_LAST));
	assign start_seen = (rstate == R_IDLE) & rx_en & ~rwait & ~rx_pin;
	assign push_new   = (rstate == R_STOP) & rx_sample & (count != `UFC_FIFO_FULL);
	// Held fourth char moves in as the host pops
	assign push       = push_new | (pop & rwait);
	assign push_data  = rshift;

	// Pin synchronisers; only the second stage is read
	always @(posedge clk_i) begin
		if (srst_i) begin
			cts_s <= 2'b11;
			rx_s  <= 2'b11;
			ext_s <= 2'b00;
			hwr_s <= 2'b00;
		end else if (ce_i) begin
			cts_s <= {cts_s[0], clear_to_send_n_i};
			rx_s  <= {rx_s[0], rx_i};
			ext_s <= {ext_s[0], external_clock_input_i};
			hwr_s <= {hwr_s[0], rx_hw_reset_i};
		end
	end

	// Register writes and rate-test toggle
	always @(posedge clk_i) begin
		if (srst_i) begin
			mode1     <= `UFC_RST_BYTE;
			mode2     <= `UFC_RST_BYTE;
			test_reg  <= `UFC_RST_BYTE;
			csel      <= `UFC_RST_BYTE;
			aux       <= `UFC_RST_BYTE;
			opr       <= `UFC_RST_BYTE;
			rate_test <= 1'b0;
		end else if (ce_i) begin
			if (ufc_hit(wr_i, addr_i, `UFC_A_MODE1))
				mode1 <= wdata_i;
			if (ufc_hit(wr_i, addr_i, `UFC_A_MODE2))
				mode2 <= wdata_i;
			if (ufc_hit(wr_i, addr_i, `UFC_A_TEST))
				test_reg <= wdata_i;
			if (ufc_hit(wr_i, addr_i, `UFC_A_CSEL))
				csel <= wdata_i;
			if (ufc_hit(wr_i, addr_i, `UFC_A_AUX))
				aux <= wdata_i;
			// Set and clear act only where ones stand
			if (ufc_hit(wr_i, addr_i, `UFC_A_OPSET))
				opr <= opr | wdata_i;
			else if (ufc_hit(wr_i, addr_i, `UFC_A_OPCLR))
				opr <= opr & ~wdata_i;
			else if (cmd_wr && cmd == `UFC_CMD_RTSON)
				opr[`UFC_OP_RTS] <= 1'b1;
			else if (cmd_wr && cmd == `UFC_CMD_RTSOF)
				opr[`UFC_OP_RTS] <= 1'b0;
			if (ufc_hit(rd_i, addr_i, `UFC_A_BRGT))
				rate_test <= ~rate_test;
		end
	end

	// Receiver framing, FIFO and flow flag
	always @(posedge clk_i) begin
		if (srst_i) begin
			rstate   <= R_IDLE;
			rsub     <= 4'h0;
			rbit     <= 3'h0;
			rshift   <= `UFC_RST_BYTE;
			rwait    <= 1'b0;
			rx_en    <= 1'b0;
			rts_hold <= 1'b0;
			wr_ptr   <= 2'h0;
			rd_ptr   <= 2'h0;
			count    <= 2'h0;
		end else if (ce_i) begin
			if (rx_reset) begin
				rstate   <= R_IDLE;
				rwait    <= 1'b0;
				rx_en    <= 1'b0;
				rts_hold <= 1'b0;
				wr_ptr   <= 2'h0;
				rd_ptr   <= 2'h0;
				count    <= 2'h0;
			end else begin
				if (cmd_wr && cmd == `UFC_CMD_RXEN)
					rx_en <= 1'b1;
				else if (rx_disable)
					rx_en <= 1'b0;
				if (tick)
					rsub <= rsub + 4'h1;
				// FIFO pointers; a held char keeps count level
				if (push)
					wr_ptr <= ufc_next_ptr(wr_ptr);
				if (pop)
					rd_ptr <= ufc_next_ptr(rd_ptr);
				if (push && !pop)
					count <= count + 2'h1;
				else if (pop && !push)
					count <= count - 2'h1;
				if (pop)
					rwait <= 1'b0;
				if (start_seen && count == `UFC_FIFO_FULL)
					rts_hold <= 1'b1;
				else if (pop && !rwait)
					rts_hold <= 1'b0;
				case (rstate)
					R_IDLE: begin
						if (start_seen) begin
							rstate <= R_START;
							rsub   <= 4'h0;
						end
					end
					R_START: begin
						// False start returns to idle
						if (rx_mid) begin
							rstate <= rx_pin ? R_IDLE : R_DATA;
							rsub   <= 4'h0;
							rbit   <= 3'h0;
						end
					end
					R_DATA: begin
						if (rx_sample) begin
							rshift <= {rx_pin, rshift[7:1]};
							rbit   <= rbit + 3'h1;
							if (rbit == `UFC_LAST_BIT)
								rstate <= R_STOP;
						end
					end
					R_STOP: begin
						if (rx_sample) begin
							rstate <= R_IDLE;
							// Fourth char waits in the shifter
							if (count == `UFC_FIFO_FULL)
								rwait <= 1'b1;
						end
					end
					default: rstate <= R_IDLE;
				endcase
			end
		end
	end

	// FIFO storage, one entry per generate step
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : fifo_slot
			always @(posedge clk_i) begin
				if (srst_i)
					fifo_mem[g] <= `UFC_RST_BYTE;
				else if (ce_i && push && !rx_reset && wr_ptr == g)
					fifo_mem[g] <= push_data;
			end
		end
	endgenerate

	assign pin_term = (~mode1[`UFC_M1_RTS] | ~rts_hold) & (~mode2[`UFC_M2_TXMP] | ~tx_empty);

	// Pins, test port and read data
	always @(posedge clk_i) begin
		if (srst_i) begin
			request_to_send_n_o <= 1'b1;
			output_port_o       <= 8'hff;
			rdata_o             <= `UFC_RST_BYTE;
		end else if (ce_i) begin
			request_to_send_n_o <= ~(opr[`UFC_OP_RTS] & pin_term);
			if (test_reg[`UFC_TEST_1X])
				output_port_o <= {rstate, tick, rts_hold, tx_ready, tx_empty};
			else
				output_port_o <= ~opr;
			rdata_o <= `UFC_RST_BYTE;
			if (rd_i) begin
				case (addr_i)
					`UFC_A_MODE1: rdata_o <= mode1;
					`UFC_A_MODE2: rdata_o <= mode2;
					`UFC_A_TEST:  rdata_o <= test_reg;
					`UFC_A_CSEL:  rdata_o <= csel;
					`UFC_A_AUX:   rdata_o <= aux;
					`UFC_A_STAT:  rdata_o <= {rate_test, cts_s[1], rx_en, tx_enabled,
						tx_empty, tx_ready, rwait | (count == `UFC_FIFO_FULL), count != 2'h0};
					`UFC_A_DATA:  rdata_o <= fifo_mem[rd_ptr];
					`UFC_A_BRGT:  rdata_o <= {7'h00, rate_test};
					default:      rdata_o <= `UFC_RST_BYTE;
				endcase
			end
		end
	end

	// Rate selection; timer tick is already on this clock
	ufc_baud u_baud (
		.clk_i        (clk_i),
		.srst_i       (srst_i),
		.ce_i         (ce_i),
		.code_i       (csel[`UFC_CS_HI:`UFC_CS_LO]),
		.rate_set_i   (aux[`UFC_AUX_SET]),
		.rate_test_i  (rate_test),
		.test_1x_i    (test_reg[`UFC_TEST_1X]),
		.timer_tick_i (timer_tick_i),
		.ext_clk_i    (ext_s[1]),
		.tick_o       (tick),
		.one_x_o      (one_x)
	);

	// Transmitter; host should check ready before a late disable
	ufc_tx u_tx (
		.clk_i      (clk_i),
		.srst_i     (srst_i),
		.ce_i       (ce_i),
		.tick_i     (tick),
		.one_x_i    (one_x),
		.load_i     (ufc_hit(wr_i, addr_i, `UFC_A_DATA)),
		.data_i     (wdata_i),
		.enable_i   (cmd_wr & (cmd == `UFC_CMD_TXEN)),
		.disable_i  (cmd_wr & (cmd == `UFC_CMD_TXDIS)),
		.cts_gate_i (mode2[`UFC_M2_CTS]),
		.cts_n_i    (cts_s[1]),
		.line_o     (tx_o),
		.ready_o    (tx_ready),
		.empty_o    (tx_empty),
		.enabled_o  (tx_enabled)
	);

	assign transmitter_ready_flag_o = tx_ready;
	assign transmitter_empty_flag_o = tx_empty;

endmodule

// [verification/ufc_monitor.sv]
`timescale 1ns/100ps
`include "ufc_defines.vh"
// Port-level checks; control bits are shadowed from bus writes and rate-test reads
module ufc_monitor (
	input wire       clk_i,
	input wire       srst_i,
	input wire [3:0] addr_i,
	input wire [7:0] wdata_i,
	input wire       wr_i,
	input wire       rd_i,
	input wire       clear_to_send_n_i,
	input wire [7:0] rdata_o,
	input wire       tx_o,
	input wire       request_to_send_n_o,
	input wire [7:0] output_port_o,
	input wire       transmitter_ready_flag_o,
	input wire       transmitter_empty_flag_o
);
	reg       rx_own, tx_own, gate, opr0, rt, tm; // Shadow bits
	reg [7:0] cnt;                                // Gated idle cycles
	wire      cmd = wr_i && addr_i == `UFC_A_CMD;
	// Shadow of written control bits and the read-toggled rate-test bit
	always @(posedge clk_i) begin
		if (srst_i) begin
			{rx_own, tx_own, gate, opr0, rt, tm} <= 6'h00;
		end else begin
			if (wr_i && addr_i == `UFC_A_MODE1) rx_own <= wdata_i[`UFC_M1_RTS];
			if (wr_i && addr_i == `UFC_A_MODE2) {tx_own, gate} <= wdata_i[5:4];
			if (wr_i && addr_i == `UFC_A_TEST) tm <= wdata_i[`UFC_TEST_1X];
			if ((wr_i && addr_i == `UFC_A_OPSET && wdata_i[0]) || (cmd && wdata_i[7:4] == `UFC_CMD_RTSON)) opr0 <= 1'b1;
			if ((wr_i && addr_i == `UFC_A_OPCLR && wdata_i[0]) || (cmd && wdata_i[7:4] == `UFC_CMD_RTSOF)) opr0 <= 1'b0;
			if (rd_i && addr_i == `UFC_A_BRGT) rt <= !rt;
		end
	end
	// Bound is generous: a pending start may still commit first
	always @(posedge clk_i) begin
		if (srst_i || !(gate && clear_to_send_n_i && transmitter_empty_flag_o)) cnt <= 8'h00;
		else if (cnt != 8'hff) cnt <= cnt + 8'h01;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	sequence load_s;
		wr_i && addr_i == `UFC_A_DATA && transmitter_ready_flag_o && transmitter_empty_flag_o;
	endsequence
	sequence txoff_s;
		wr_i && addr_i == `UFC_A_CMD && wdata_i[7:4] == `UFC_CMD_TXDIS;
	endsequence
	direct_pin_a: assert property (!rx_own && !tx_own |=> request_to_send_n_o == !$past(opr0))
		else $error("pin differs from port bit");
	port_low_a: assert property (!opr0 |=> request_to_send_n_o)
		else $error("pin low with port bit clear");
	tx_pin_a: assert property (tx_own && transmitter_empty_flag_o |=> request_to_send_n_o)
		else $error("pin low while transmitter empty");
	rate_read_a: assert property (rd_i && addr_i == `UFC_A_BRGT |=> rdata_o == {7'h00, $past(rt)})
		else $error("rate test read wrong");
	cts_stop_a: assert property (cnt > 8'hc8 |-> transmitter_empty_flag_o)
		else $error("character sent while gated");
	start_ready_a: assert property ($fell(tx_o) && $past(transmitter_empty_flag_o) |-> !transmitter_ready_flag_o[*8])
		else $error("ready early in start bit");
	empty_start_a: assert property ($fell(transmitter_empty_flag_o) |-> !tx_o)
		else $error("empty cleared without start bit");
	early_off_a: assert property (load_s ##2 txoff_s |=> ##40 transmitter_empty_flag_o)
		else $error("character sent after early disable");
	port_inv_a: assert property (!tm ##1 (!tm && $stable(opr0)) |-> output_port_o[0] == !opr0)
		else $error("port pin not inverse of port bit");
endmodule

bind ufc_top ufc_monitor mon (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .clear_to_send_n_i(clear_to_send_n_i), .rdata_o(rdata_o), .tx_o(tx_o),
	.request_to_send_n_o(request_to_send_n_o), .output_port_o(output_port_o),
	.transmitter_ready_flag_o(transmitter_ready_flag_o), .transmitter_empty_flag_o(transmitter_empty_flag_o));

// [verification/ufc_remote.sv]
`timescale 1ns/100ps
// Remote serial end: 8N1, LSB first, BIT cycles a bit
module ufc_remote #(parameter int BIT = 64) (
	input  wire logic       clk_i,
	input  wire logic       line_i,
	output logic            line_o,
	output logic            got_o,
	output logic [7:0]      byte_o
);
	initial begin
		line_o = 1'b1;
		got_o = 1'b0;
		byte_o = 8'h00;
	end
	// Remote transmitter, idle high between frames
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 10; i++) begin
			line_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
			repeat (BIT) @(posedge clk_i);
		end
	endtask
	// Remote receiver, mid-bit sampling; bad stop gives no byte
	always begin
		@(negedge line_i);
		repeat (BIT/2) @(posedge clk_i);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT) @(posedge clk_i);
			if (i < 8) byte_o[i] <= line_i;
		end
		got_o <= line_i;
		@(posedge clk_i);
		got_o <= 1'b0;
	end
endmodule

// [verification/ufc_top_test.sv]
`timescale 1ns/100ps
`include "ufc_defines.vh"
module ufc_top_test;
	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        rd_d = 1'b0;
	logic        cts_n = 1'b0;
	logic        ext_clk = 1'b0;
	logic        hw_rst = 1'b0;
	logic        tick = 1'b0;
	logic [1:0]  tcnt = 2'h0;
	logic [3:0]  addr_i = 4'h0;
	logic [7:0]  wdata_i = 8'h00;
	logic [7:0]  rdata_o, port_o, got_byte, b;
	logic [7:0]  rx_b[4];
	logic        tx_o, rts_n, rdy, emp, rx, got;
	logic [15:0] rq[$];                  // Read notes: mask, value
	logic [7:0]  tq[$];                  // Bytes due on the line
	int          mismatches = 0;
	int          compares = 0;
	ufc_top dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .clear_to_send_n_i(cts_n), .rx_i(rx), .external_clock_input_i(ext_clk), .rx_hw_reset_i(hw_rst),
		.timer_tick_i(tick), .rdata_o(rdata_o), .tx_o(tx_o), .request_to_send_n_o(rts_n), .output_port_o(port_o),
		.transmitter_ready_flag_o(rdy), .transmitter_empty_flag_o(emp));
	ufc_remote #(.BIT(64)) far (.clk_i(clk_i), .line_i(tx_o), .line_o(rx), .got_o(got), .byte_o(got_byte));
	initial forever #5 clk_i = ~clk_i;
	always #37 ext_clk = ~ext_clk;
	// Timer tick every fourth cycle gives a 64-cycle bit
	always @(posedge clk_i) begin
		tcnt <= tcnt + 2'h1;
		tick <= (tcnt == 2'h3);
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		rq.push_back({m, e});
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Pin is registered: let it settle first
	task automatic pin(input logic e);
		cyc(3);
		chk({7'h00, rts_n}, {7'h00, e});
	endtask
	task automatic send(input logic [7:0] d);
		tq.push_back(d);
		wr(`UFC_A_DATA, d);
	endtask
	// Bounded wait for all due bytes and an idle, empty transmitter
	task automatic drain();
		int n;
		n = 0;
		while ((tq.size() != 0 || !emp) && n < 4000) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 4000) begin
			mismatches++;
			final_report();
		end
	endtask
	// Watcher: oldest note against each answer
	always @(posedge clk_i) begin
		rd_d <= rd_i;
		if (rd_d) chk(rdata_o & rq[0][15:8], rq[0][7:0]);
		if (rd_d) void'(rq.pop_front());
		if (got) chk(got_byte, tq.size() ? tq.pop_front() : 8'hxx);
	end
	initial begin
		#1000000;
		mismatches++;
		final_report();
	end
	initial begin
		void'($urandom(8));
		cyc(12);
		srst_i <= 1'b0;
		cyc(3);
		chk({7'h00, rts_n}, 8'h01);
		rd(`UFC_A_STAT, 8'hbf, 8'h08);
		wr(`UFC_A_CSEL, {`UFC_CS_TIMER, 4'h0});
		wr(`UFC_A_CMD, {`UFC_CMD_TXEN, 4'h0});
		rd(`UFC_A_STAT, 8'h1c, 8'h1c);
		send(8'($urandom));
		drain();
		$display("test send done");
		// Gate on, clear-to-send negated: character waits
		wr(`UFC_A_MODE2, 8'h10);
		cts_n <= 1'b1;
		cyc(4);
		b = 8'($urandom);
		wr(`UFC_A_DATA, b);
		cyc(300);
		rd(`UFC_A_STAT, 8'h08, 8'h08);
		tq.push_back(b);
		cts_n <= 1'b0;
		drain();
		wr(`UFC_A_MODE2, 8'h00);
		cts_n <= 1'b1;
		send(8'($urandom));
		drain();
		cts_n <= 1'b0;
		$display("test gate done");
		// Disable two cycles after a load in underrun
		rd(`UFC_A_STAT, 8'h04, 8'h04);
		wr(`UFC_A_DATA, 8'($urandom));
		wr(`UFC_A_CMD, {`UFC_CMD_TXDIS, 4'h0});
		cyc(800);
		rd(`UFC_A_STAT, 8'h18, 8'h08);
		wr(`UFC_A_CMD, {`UFC_CMD_TXEN, 4'h0});
		// Commands and port writes: on, off, set, clear
		for (int i = 0; i < 4; i++) begin
			wr(i[1] ? (i[0] ? `UFC_A_OPCLR : `UFC_A_OPSET) : `UFC_A_CMD, i[1] ? 8'h01 : (i[0] ? 8'h90 : 8'h80));
			pin(i[0]);
			chk({7'h00, port_o[0]}, {7'h00, i[0]});
		end
		wr(`UFC_A_OPSET, 8'h01);
		wr(`UFC_A_MODE2, 8'h20);
		pin(1'b1);
		send(8'($urandom));
		cyc(40);
		pin(1'b0);
		drain();
		cyc(64);
		pin(1'b1);
		wr(`UFC_A_MODE2, 8'h00);
		$display("test pin done");
		// Flow control: fourth start negates request
		wr(`UFC_A_CMD, {`UFC_CMD_RXEN, 4'h0});
		wr(`UFC_A_MODE1, 8'h80);
		pin(1'b0);
		for (int i = 0; i < 4; i++) begin
			rx_b[i] = 8'($urandom);
			if (i == 3) pin(1'b0);
			far.send(rx_b[i]);
		end
		pin(1'b1);
		for (int i = 0; i < 4; i++) rd(`UFC_A_DATA, 8'hff, rx_b[i]);
		pin(1'b0);
		wr(`UFC_A_MODE1, 8'h00);
		wr(`UFC_A_OPCLR, 8'h01);
		pin(1'b1);
		$display("test flow done");
		rd(`UFC_A_BRGT, 8'hff, 8'h00);
		rd(`UFC_A_BRGT, 8'hff, 8'h01);
		rd(`UFC_A_STAT, 8'h80, 8'h00);
		rd(4'hb, 8'hff, 8'h00);
		// Wake mode holds the receiver on
		wr(`UFC_A_MODE1, 8'h18);
		wr(`UFC_A_CMD, {`UFC_CMD_RXDIS, 4'h0});
		wr(`UFC_A_CMD, {`UFC_CMD_RXRST, 4'h0});
		rd(`UFC_A_STAT, 8'h20, 8'h20);
		wr(`UFC_A_MODE1, 8'h00);
		hw_rst <= 1'b1;
		cyc(4);
		hw_rst <= 1'b0;
		cyc(4);
		rd(`UFC_A_STAT, 8'h20, 8'h00);
		rd(`UFC_A_CSEL, 8'hff, 8'hd0);
		wr(`UFC_A_CMD, {`UFC_CMD_RXEN, 4'h0});
		rd(`UFC_A_STAT, 8'h20, 8'h20);
		$display("test receiver done");
		// Test mode: port shows ready and empty of an idle transmitter
		wr(`UFC_A_TEST, 8'h01);
		cyc(2);
		chk(port_o & 8'h03, 8'h03);
		wr(`UFC_A_TEST, 8'h00);
		$display("test mode done");
		cyc(4);
		final_report();
	end
endmodule
